// [hdl/supervisor_pkg.sv]
// Constants, layouts and types shared by the system supervisor and watchdog.
package supervisor_pkg;
	localparam logic [6:0] ADDR_CTRL1 = 7'h01;
	localparam logic [6:0] ADDR_DUTY = 7'h08;
	localparam logic [6:0] ADDR_WD_CFG = 7'h0A;
	localparam logic [6:0] ADDR_WD_CTL = 7'h0C;
	localparam logic [6:0] ADDR_STATUS = 7'h0D;

	localparam int CTRL_HOLD_BIT = 7;
	localparam int CTRL_TEST_BIT = 6;
	localparam int CTRL_SUPPLY_BIT = 4;
	localparam int CTRL_MIRROR_BIT = 2;
	localparam logic [7:0] CTRL1_WR_MASK = 8'hD6;
	localparam logic [7:0] CTRL1_RESET = 8'h12;
	localparam logic [6:0] DUTY_RESET = 7'h00;
	localparam logic [6:0] DUTY_FULL = 7'h64;

	localparam int STAT_ANY_BIT = 7;
	localparam int STAT_KEY_BIT = 6;
	localparam int STAT_HOLD_BIT = 5;
	localparam int STAT_PIN_BIT = 4;
	localparam int STAT_SPI_ERR_BIT = 3;
	localparam logic [3:0] STAT_STICKY_RESET = 4'h0;
	localparam logic [7:0] STAT_TEST_RESET = 8'h40;

	localparam int WD_EN_BIT = 7;
	localparam int WD_X1S_BIT = 6;
	localparam int WD_X100_BIT = 5;
	localparam int WD_X10_BIT = 4;
	localparam logic [7:0] WD_CFG_RESET = 8'hCA;
	localparam logic [6:0] WD_CTL_RESET = 7'h00;
	localparam logic [3:0] WD_VAL_MIN = 4'h1;
	localparam logic [3:0] WD_VAL_MAX = 4'hA;
	localparam logic [9:0] WD_TICKS_1S = 10'h064;
	localparam logic [9:0] WD_TICKS_100MS = 10'h00A;
	localparam logic [9:0] WD_TICKS_10MS = 10'h001;
	localparam logic [9:0] WD_DEFAULT_TICKS = 10'h3E8;

	localparam int CLK_HZ = 40000000;
	localparam int BASE_TIME_MS = 10;
	localparam int BASE_CYCLES = CLK_HZ / 1000 * BASE_TIME_MS;
	localparam int RST_PULSE_US = 10;
	localparam int RST_PULSE_CYCLES = CLK_HZ / 1000000 * RST_PULSE_US;
	localparam int PWM_STEP_US = 10;
	localparam int PWM_STEP_CYCLES = CLK_HZ / 1000000 * PWM_STEP_US;
	localparam logic [6:0] PWM_LAST_STEP = 7'h63;
	localparam logic [4:0] FRAME_LAST_BIT = 5'h0F;
	localparam logic [4:0] FRAME_OVER_BIT = 5'h10;
	localparam logic [4:0] FRAME_DATA_BIT = 5'h08;

	typedef struct packed {
		logic wr;
		logic [6:0] addr;
		logic [7:0] data;
	} spi_frame_t;

	typedef enum logic [0:0] {
		WD_RUN = 1'b0,
		WD_PULSE = 1'b1
	} wd_state_t;
endpackage

// [hdl/system_supervisor_watchdog.sv]
// System supervisor: control and status registers, key-mirror output and watchdog behind SPI.
`timescale 1ns/10ps
`default_nettype none
module system_supervisor_watchdog #(
	parameter int BASE_CYCLES = supervisor_pkg::BASE_CYCLES,
	parameter int RST_PULSE_CYCLES = supervisor_pkg::RST_PULSE_CYCLES,
	parameter int PWM_STEP_CYCLES = supervisor_pkg::PWM_STEP_CYCLES
) (
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic mosi_i,
	output logic miso_o,
	input wire logic key_i,
	input wire logic mirror_pin_i,
	input wire logic [2:0] supply_fault_i,
	input wire logic other_any_fault_i,
	output logic host_reset_n_o,
	output logic power_hold_o,
	output logic self_test_o,
	output logic sensor_supply_en_o,
	output logic key_mirror_o
);
	localparam int PW = $clog2(RST_PULSE_CYCLES + 1);

	logic rst_q1;
	logic rst_n;

	// Release of the reset is synchronised; assertion stays asynchronous.
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_q1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_n <= rst_q1;
		end
	end

	// Link side: runs only while the frame clock toggles; chip select ends every frame.
	logic [4:0] bit_cnt;
	logic [14:0] shift;
	supervisor_pkg::spi_frame_t frame_word;
	logic frame_tog;
	logic err_tog;
	logic [7:0] rd_data;

	always_ff @(posedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			bit_cnt <= 5'h00;
			shift <= 15'h0000;
		end else begin
			shift <= {shift[13:0], mosi_i};
			if (bit_cnt != supervisor_pkg::FRAME_OVER_BIT + 5'h01) begin
				bit_cnt <= bit_cnt + 5'h01;
			end
		end
	end

	always_ff @(posedge sclk_i or negedge rst_n) begin
		if (!rst_n) begin
			frame_word <= '0;
			frame_tog <= 1'b0;
			err_tog <= 1'b0;
		end else if (!cs_n_i) begin
			if (bit_cnt == supervisor_pkg::FRAME_LAST_BIT) begin
				frame_word <= {shift, mosi_i};
				frame_tog <= ~frame_tog;
			end
			if (bit_cnt == supervisor_pkg::FRAME_OVER_BIT) begin
				err_tog <= ~err_tog;
			end
		end
	end

	// Read data is only updated between frames, so it is stable while shifted out.
	always_ff @(negedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			miso_o <= 1'b0;
		end else if (bit_cnt >= supervisor_pkg::FRAME_DATA_BIT && bit_cnt <= supervisor_pkg::FRAME_LAST_BIT) begin
			miso_o <= rd_data[3'(supervisor_pkg::FRAME_LAST_BIT - bit_cnt)];
		end else begin
			miso_o <= 1'b0;
		end
	end

	// Event toggles and pin levels cross into the system clock through two flops.
	logic [7:0] sync1;
	logic [7:0] sync2;
	logic frame_seen;
	logic err_seen;

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			sync1 <= 8'h00;
			sync2 <= 8'h00;
			frame_seen <= 1'b0;
			err_seen <= 1'b0;
		end else begin
			sync1 <= {frame_tog, err_tog, key_i, mirror_pin_i, supply_fault_i, other_any_fault_i};
			sync2 <= sync1;
			frame_seen <= sync2[7];
			err_seen <= sync2[6];
		end
	end

	logic frame_ev;
	logic err_ev;
	logic key_s;
	logic pin_s;
	logic [2:0] fault_s;
	logic other_s;
	logic wr_ev;

	assign frame_ev = sync2[7] ^ frame_seen;
	assign err_ev = sync2[6] ^ err_seen;
	assign key_s = sync2[5];
	assign pin_s = sync2[4];
	assign fault_s = sync2[3:1];
	assign other_s = sync2[0];
	assign wr_ev = frame_ev && frame_word.wr;

	logic [7:0] ctrl1;
	logic [6:0] duty;
	logic [3:0] sticky;
	logic [7:0] test_img;
	logic [7:0] wd_cfg;
	logic [6:0] wd_ctl;
	logic [9:0] wd_cnt;
	logic [PW-1:0] pulse_cnt;
	supervisor_pkg::wd_state_t state;
	logic wd_done;
	logic refresh;
	logic [6:0] temp_src;
	logic [9:0] load_val;
	logic [7:0] stat_live;
	logic [7:0] rd_mux;
	logic base_tick;
	logic pwm_tick;
	logic [6:0] pwm_step;

	assign wd_done = state == supervisor_pkg::WD_PULSE && pulse_cnt == '0;
	assign refresh = wr_ev && frame_word.addr == supervisor_pkg::ADDR_WD_CTL && frame_word.data[7];

	function automatic logic [9:0] wd_ticks(input logic [6:0] t);
		logic [9:0] m;
		logic [3:0] v;
		if (t[supervisor_pkg::WD_X1S_BIT]) begin
			m = supervisor_pkg::WD_TICKS_1S;
		end else if (t[supervisor_pkg::WD_X100_BIT]) begin
			m = supervisor_pkg::WD_TICKS_100MS;
		end else begin
			m = supervisor_pkg::WD_TICKS_10MS;
		end
		v = t[3:0];
		if (v == 4'h0) begin
			v = supervisor_pkg::WD_VAL_MIN;
		end else if (v > supervisor_pkg::WD_VAL_MAX) begin
			v = supervisor_pkg::WD_VAL_MAX;
		end
		return 10'(m * {6'h00, v});
	endfunction

	// A temporary time carried by the refresh write itself counts as held in the control register.
	assign temp_src = (frame_word.data[6:0] != 7'h00) ? frame_word.data[6:0] : wd_ctl;
	assign load_val = wd_ticks((temp_src != 7'h00) ? temp_src : wd_cfg[6:0]);

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			ctrl1 <= supervisor_pkg::CTRL1_RESET;
		end else if (wd_done) begin
			ctrl1[supervisor_pkg::CTRL_TEST_BIT] <= 1'b0;
		end else if (wr_ev && frame_word.addr == supervisor_pkg::ADDR_CTRL1) begin
			ctrl1 <= frame_word.data & supervisor_pkg::CTRL1_WR_MASK;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			duty <= supervisor_pkg::DUTY_RESET;
		end else if (wr_ev && frame_word.addr == supervisor_pkg::ADDR_DUTY) begin
			duty <= frame_word.data[6:0];
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			wd_cfg <= supervisor_pkg::WD_CFG_RESET;
		end else if (wd_done) begin
			wd_cfg <= supervisor_pkg::WD_CFG_RESET;
		end else if (wr_ev && frame_word.addr == supervisor_pkg::ADDR_WD_CFG) begin
			wd_cfg <= frame_word.data;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			wd_ctl <= supervisor_pkg::WD_CTL_RESET;
		end else if (refresh || wd_done) begin
			wd_ctl <= supervisor_pkg::WD_CTL_RESET;
		end else if (wr_ev && frame_word.addr == supervisor_pkg::ADDR_WD_CTL) begin
			wd_ctl <= frame_word.data[6:0];
		end
	end

	// Supply and SPI faults are sticky; a clearing write loses to a fault arriving in the same cycle.
	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			sticky <= supervisor_pkg::STAT_STICKY_RESET;
			test_img <= supervisor_pkg::STAT_TEST_RESET;
		end else begin
			if (wr_ev && frame_word.addr == supervisor_pkg::ADDR_STATUS && ctrl1[supervisor_pkg::CTRL_TEST_BIT]) begin
				test_img <= frame_word.data;
			end
			if (wr_ev && frame_word.addr == supervisor_pkg::ADDR_STATUS && !ctrl1[supervisor_pkg::CTRL_TEST_BIT]) begin
				sticky <= (sticky & frame_word.data[3:0]) | {err_ev, fault_s};
			end else begin
				sticky <= sticky | {err_ev, fault_s};
			end
		end
	end

	always_comb begin
		stat_live = {1'b0, ~key_s, ctrl1[supervisor_pkg::CTRL_HOLD_BIT], pin_s, sticky};
		stat_live[supervisor_pkg::STAT_ANY_BIT] = other_s | (|sticky);
	end

	always_comb begin
		case (frame_word.addr)
			supervisor_pkg::ADDR_CTRL1: rd_mux = ctrl1;
			supervisor_pkg::ADDR_DUTY: rd_mux = {1'b0, duty};
			supervisor_pkg::ADDR_WD_CFG: rd_mux = {wd_cfg[supervisor_pkg::WD_EN_BIT], (wd_cnt > 10'h07F) ? 7'h7F : wd_cnt[6:0]};
			supervisor_pkg::ADDR_WD_CTL: rd_mux = {1'b0, wd_ctl};
			supervisor_pkg::ADDR_STATUS: rd_mux = ctrl1[supervisor_pkg::CTRL_TEST_BIT] ? test_img : stat_live;
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= 8'h00;
		end else if (frame_ev) begin
			rd_data <= rd_mux;
		end
	end

	tick_divider #(.CYCLES(BASE_CYCLES)) base_div (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n),
		.clr_i(refresh || wd_done),
		.tick_o(base_tick)
	);

	tick_divider #(.CYCLES(PWM_STEP_CYCLES)) pwm_div (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n),
		.clr_i(1'b0),
		.tick_o(pwm_tick)
	);

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			state <= supervisor_pkg::WD_RUN;
			wd_cnt <= supervisor_pkg::WD_DEFAULT_TICKS;
			pulse_cnt <= '0;
			host_reset_n_o <= 1'b0;
		end else begin
			case (state)
				supervisor_pkg::WD_RUN: begin
					host_reset_n_o <= 1'b1;
					if (refresh) begin
						wd_cnt <= load_val;
					end else if (base_tick && wd_cfg[supervisor_pkg::WD_EN_BIT]) begin
						if (wd_cnt <= 10'h001) begin
							state <= supervisor_pkg::WD_PULSE;
							pulse_cnt <= PW'(RST_PULSE_CYCLES - 1);
							host_reset_n_o <= 1'b0;
						end else begin
							wd_cnt <= wd_cnt - 10'h001;
						end
					end
				end
				supervisor_pkg::WD_PULSE: begin
					if (pulse_cnt == '0) begin
						state <= supervisor_pkg::WD_RUN;
						host_reset_n_o <= 1'b1;
						wd_cnt <= supervisor_pkg::WD_DEFAULT_TICKS;
					end else begin
						pulse_cnt <= pulse_cnt - 1'b1;
					end
				end
				default: state <= supervisor_pkg::WD_RUN;
			endcase
		end
	end

	// One PWM period is one hundred steps, so each duty code is one percent.
	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			pwm_step <= 7'h00;
			key_mirror_o <= 1'b0;
		end else begin
			if (pwm_tick) begin
				pwm_step <= (pwm_step == supervisor_pkg::PWM_LAST_STEP) ? 7'h00 : pwm_step + 7'h01;
			end
			key_mirror_o <= ctrl1[supervisor_pkg::CTRL_MIRROR_BIT] && (duty >= supervisor_pkg::DUTY_FULL || pwm_step < duty);
		end
	end

	assign power_hold_o = ctrl1[supervisor_pkg::CTRL_HOLD_BIT];
	assign self_test_o = ctrl1[supervisor_pkg::CTRL_TEST_BIT];
	assign sensor_supply_en_o = ctrl1[supervisor_pkg::CTRL_SUPPLY_BIT];

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n);

	a_hold_write: assert property (wr_ev && frame_word.addr == supervisor_pkg::ADDR_CTRL1 |=> power_hold_o == $past(frame_word.data[7])) else $error("power hold not taken from write");
	a_test_write: assert property (wr_ev && frame_word.addr == supervisor_pkg::ADDR_CTRL1 && !wd_done |=> self_test_o == $past(frame_word.data[6])) else $error("self-test bit not taken from write");
	a_mirror_off: assert property (!ctrl1[supervisor_pkg::CTRL_MIRROR_BIT] |=> !key_mirror_o) else $error("mirror on while disabled");
	a_full_duty: assert property (ctrl1[supervisor_pkg::CTRL_MIRROR_BIT] && duty >= supervisor_pkg::DUTY_FULL |=> key_mirror_o) else $error("full duty not held on");
	a_any_fault: assert property (other_s || sticky != 4'h0 |-> stat_live[7]) else $error("global fault flag missing");
	a_key_status: assert property (stat_live[6] != key_s && stat_live[5] == power_hold_o && stat_live[4] == pin_s) else $error("live status wrong");
	a_refresh_load: assert property (refresh && state == supervisor_pkg::WD_RUN |=> wd_cnt == $past(load_val) && wd_ctl == 7'h00) else $error("refresh did not reload");
	a_expire_pulse: assert property (state == supervisor_pkg::WD_RUN && base_tick && !refresh && wd_cfg[7] && wd_cnt <= 10'h001 |=> !host_reset_n_o ##1 !host_reset_n_o) else $error("expiry gave no reset pulse");
	a_pulse_restore: assert property ($rose(host_reset_n_o) && $past(state) == supervisor_pkg::WD_PULSE |-> wd_cfg == supervisor_pkg::WD_CFG_RESET && wd_cnt == supervisor_pkg::WD_DEFAULT_TICKS) else $error("default not restored");
	a_disabled_quiet: assert property (state == supervisor_pkg::WD_RUN && !wd_cfg[7] |=> state == supervisor_pkg::WD_RUN) else $error("disabled watchdog expired");
	a_decode_clamp: assert property (wd_ticks(7'h4F) == 10'h3E8 && wd_ticks(7'h70) == 10'h064 && wd_ticks(7'h12) == 10'h002) else $error("time decode wrong");

	c_refresh: cover property (refresh);
	c_expiry: cover property (state == supervisor_pkg::WD_PULSE && wd_done);
	c_selftest: cover property (wr_ev && frame_word.addr == supervisor_pkg::ADDR_STATUS && self_test_o);
	c_mirror_pwm: cover property (key_mirror_o ##1 !key_mirror_o);
endmodule // system_supervisor_watchdog
`default_nettype wire

// [hdl/tick_divider.sv]
// Free-running divider that pulses once every CYCLES clocks and can be restarted.
`timescale 1ns/10ps
`default_nettype none
module tick_divider #(
	parameter int CYCLES = 400
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic clr_i,
	output logic tick_o
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	logic [CW-1:0] count;

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count <= '0;
			tick_o <= 1'b0;
		end else if (clr_i) begin
			count <= '0;
			tick_o <= 1'b0;
		end else if (count == LAST) begin
			count <= '0;
			tick_o <= 1'b1;
		end else begin
			count <= count + 1'b1;
			tick_o <= 1'b0;
		end
	end
endmodule // tick_divider
`default_nettype wire

// [testbench/host_spi_model.sv]
// Host controller model that sends 16-bit SPI words to the supervisor.
`timescale 1ns/10ps
`default_nettype none
module host_spi_model (
	output logic sclk_o,
	output logic cs_n_o,
	output logic mosi_o,
	input wire logic miso_i
);
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end

	// One word per frame; the second half shifts back the answer to the previous frame.
	task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] data, output logic [7:0] rdata);
		logic [15:0] word;
		word = {wr, addr, data};
		rdata = 8'h00;
		cs_n_o = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			mosi_o = word[i];
			#15 sclk_o = 1'b1;
			if (i < 8) rdata = {rdata[6:0], miso_i};
			#15 sclk_o = 1'b0;
		end
		#15 cs_n_o = 1'b1;
		// The released data line flips so a stale level is never mistaken for a driven bit.
		mosi_o = ~mosi_o;
		#300;
	endtask

	// Clocks a frame of n zero bits, used for runt and over-length frames.
	task automatic runt(input int n);
		cs_n_o = 1'b0;
		mosi_o = 1'b0;
		repeat (n) begin
			#15 sclk_o = 1'b1;
			#15 sclk_o = 1'b0;
		end
		#15 cs_n_o = 1'b1;
		mosi_o = ~mosi_o;
		#300;
	endtask
endmodule // host_spi_model
`default_nettype wire

// [testbench/system_supervisor_watchdog_tb_top.sv]
// Self-checking testbench for the system supervisor and watchdog.
`timescale 1ns/10ps
`default_nettype none
module system_supervisor_watchdog_tb_top;
	localparam int BASE = 20;
	localparam int PULSE = 4;
	localparam int STEP = 2;
	localparam logic [6:0] A_CTRL = supervisor_pkg::ADDR_CTRL1;
	localparam logic [6:0] A_DUTY = supervisor_pkg::ADDR_DUTY;
	localparam logic [6:0] A_CFG = supervisor_pkg::ADDR_WD_CFG;
	localparam logic [6:0] A_CTL = supervisor_pkg::ADDR_WD_CTL;
	localparam logic [6:0] A_STAT = supervisor_pkg::ADDR_STATUS;
	logic mclk, reset_n, sclk, cs_n, mosi, miso, key, pin, other, host_reset_n, hold, test, supply_en, mirror;
	logic [2:0] fault;
	logic [7:0] rd;
	int err_total = 0;
	int samples_checked = 0;
	int cycles = 0;
	int low_seen = 0;
	logic [7:0] t_cfg [9] = '{8'h93, 8'h95, 8'h90, 8'h9F, 8'hB1, 8'hC1, 8'h95, 8'h95, 8'h13};
	logic [7:0] t_ctl [9] = '{8'h80, 8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h92, 8'h80};
	int t_ref [9] = '{1, 1, 1, 1, 1, 1, 4, 1, 1};
	int t_exp [9] = '{60, 0, 20, 200, 200, 2000, 100, 40, 0};
	logic [6:0] p_duty [5] = '{7'h7F, 7'h64, 7'h32, 7'h01, 7'h64};
	logic [7:0] p_ctrl [5] = '{8'h84, 8'h84, 8'h84, 8'h84, 8'h80};

	system_supervisor_watchdog #(.BASE_CYCLES(BASE), .RST_PULSE_CYCLES(PULSE), .PWM_STEP_CYCLES(STEP)) dut_u (
		.mclk_i(mclk), .reset_n_i(reset_n), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso),
		.key_i(key), .mirror_pin_i(pin), .supply_fault_i(fault), .other_any_fault_i(other),
		.host_reset_n_o(host_reset_n), .power_hold_o(hold), .self_test_o(test),
		.sensor_supply_en_o(supply_en), .key_mirror_o(mirror)
	);
	host_spi_model host_u (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	// Counting is done just after the edge so it never races the design's own updates.
	always @(posedge mclk) begin
		#1;
		cycles++;
		if (host_reset_n === 1'b0) low_seen++;
		if (cycles == 20000) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, cycles, 0);
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("comparisons=%0d mismatches=%0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic check_range(input int got, input int lo, input int hi);
		samples_checked++;
		if (got < lo || got > hi) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask

	task automatic wr(input logic [6:0] addr, input logic [7:0] data);
		logic [7:0] unused;
		host_u.xfer(1'b1, addr, data, unused);
	endtask

	// A read needs a second frame, because the answer rides in the frame after the request.
	task automatic rdreg(input logic [6:0] addr, output logic [7:0] d);
		host_u.xfer(1'b0, addr, 8'h00, d);
		host_u.xfer(1'b0, 7'h7F, 8'h00, d);
	endtask

	task automatic set_in(input logic k, input logic p, input logic [2:0] f, input logic o);
		@(posedge mclk);
		key <= k;
		pin <= p;
		fault <= f;
		other <= o;
		repeat (8) @(posedge mclk);
	endtask

	task automatic check_outs(input logic [7:0] exp);
		check8({3'b000, host_reset_n, hold, test, supply_en, mirror}, exp);
	endtask

	task automatic wd_time(input logic [7:0] cfg, input logic [7:0] ctl, input int nref, input int exp);
		int n;
		int low0;
		int lows;
		if (exp != 0) wr(A_CTRL, 8'hC4);
		wr(A_CFG, cfg);
		low0 = low_seen;
		for (int i = 0; i < nref; i++) wr(A_CTL, ctl);
		check_range(low_seen - low0, 0, 0);
		n = 0;
		while (host_reset_n === 1'b1 && n < exp + 300) begin
			@(posedge mclk);
			#1;
			n++;
		end
		if (exp == 0) begin
			check_range(n, 300, 300);
		end else begin
			check_range(n, exp - 13, exp - 6);
			// The pulse is counted here, not from the shared counter, so no two processes race on one edge.
			lows = 1;
			repeat (PULSE + 4) begin
				@(posedge mclk);
				#1;
				if (host_reset_n === 1'b0) lows++;
			end
			check_range(lows, PULSE, PULSE);
			rdreg(A_CFG, rd);
			check8(rd, 8'hFF);
			check8({7'h00, test}, 8'h00);
		end
	endtask

	initial begin
		int h;
		int e;
		reset_n = 1'b0;
		key = 1'b1;
		pin = 1'b0;
		fault = 3'b000;
		other = 1'b0;
		repeat (16) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (8) @(posedge mclk);
		check_outs(8'h12);
		rdreg(A_CTRL, rd);
		check8(rd, supervisor_pkg::CTRL1_RESET);
		rdreg(A_CFG, rd);
		check8(rd, 8'hFF);
		rdreg(A_STAT, rd);
		check8(rd, 8'h00);
		wr(7'h30, 8'hFF);
		rdreg(7'h30, rd);
		check8(rd, 8'h00);
		$display("test reset_values done");

		wr(A_CTRL, 8'hFF);
		rdreg(A_CTRL, rd);
		check8(rd, 8'hD6);
		check_outs(8'h1E);
		wr(A_STAT, 8'hA5);
		rdreg(A_STAT, rd);
		check8(rd, 8'hA5);
		wr(A_CTRL, 8'h84);
		rdreg(A_CTRL, rd);
		check8(rd, 8'h84);
		check_outs(8'h18);
		$display("test control done");

		wr(A_STAT, 8'h00);
		set_in(1'b0, 1'b1, 3'b000, 1'b1);
		rdreg(A_STAT, rd);
		check8(rd, 8'hF0);
		set_in(1'b1, 1'b0, 3'b101, 1'b0);
		set_in(1'b1, 1'b0, 3'b000, 1'b0);
		rdreg(A_STAT, rd);
		check8(rd, 8'hA5);
		wr(A_STAT, 8'hFF);
		rdreg(A_STAT, rd);
		check8(rd, 8'hA5);
		wr(A_STAT, 8'h00);
		rdreg(A_STAT, rd);
		check8(rd, 8'h20);
		host_u.runt(17);
		rdreg(A_STAT, rd);
		check8(rd, 8'hA8);
		host_u.runt(12);
		wr(A_STAT, 8'h00);
		rdreg(A_STAT, rd);
		check8(rd, 8'h20);
		$display("test status done");

		for (int i = 0; i < 5; i++) begin
			wr(A_CTRL, p_ctrl[i]);
			wr(A_DUTY, {1'b0, p_duty[i]});
			repeat (10) @(posedge mclk);
			h = 0;
			repeat (200) begin
				@(posedge mclk);
				#1;
				if (mirror === 1'b1) h++;
			end
			e = p_ctrl[i][2] ? ((p_duty[i] > 7'h64) ? 100 : int'(p_duty[i])) * STEP : 0;
			check_range(h, e, e);
		end
		$display("test duty done");

		wr(A_CFG, 8'h95);
		wr(A_CTL, 8'hA5);
		rdreg(A_CTL, rd);
		check8(rd, 8'h00);
		for (int i = 0; i < 9; i++) begin
			wd_time(t_cfg[i], t_ctl[i], t_ref[i], t_exp[i]);
		end
		$display("test watchdog done");
		tally_and_finish();
	end
endmodule // system_supervisor_watchdog_tb_top
`default_nettype wire
